// ### rtl/sgpio_pkg.sv
package sgpio_pkg;
  localparam int NUM_PINS = 11;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_PERIOD_NS = 128;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W = 5;
  localparam logic [10:0] FUNC_RESET = 11'h000;
  localparam logic [10:0] DIR_RESET = 11'h000;
  localparam logic [10:0] LEVEL_RESET = 11'h000;
  // register selects on the configuration access port
  localparam logic [1:0] REG_FUNC = 2'h0;
  localparam logic [1:0] REG_DIR = 2'h1;
  localparam logic [1:0] REG_LEVEL = 2'h2;
  // pin positions of the alternate functions
  localparam int PIN_P2_RST = 0;
  localparam int PIN_P4_RST = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 3;
  localparam int PIN_IRQ2 = 4;
  localparam int PIN_EVENT = 7;
  localparam int PIN_P3_RST = 9;
  localparam int PIN_P5_RST = 10;
  // pins whose alternate function drives the pin
  localparam logic [10:0] ALT_OUT_MASK = 11'h683;
  // pins whose alternate function is an input
  localparam logic [10:0] ALT_IN_MASK = 11'h01C;
endpackage

// ### rtl/sgpio_sync.sv
`timescale 1ns/1ps
module sgpio_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [sgpio_pkg::NUM_PINS-1:0] async_i,
  output logic [sgpio_pkg::NUM_PINS-1:0] sync_o
);
  import sgpio_pkg::*;
  logic [NUM_PINS-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// ### rtl/sgpio_pins.sv
`timescale 1ns/1ps
module sgpio_pins (
  input wire logic clock_i,
  input wire logic rst_i,
  // configuration register port
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [1:0] cfg_sel_i,
  input wire logic [sgpio_pkg::NUM_PINS-1:0] cfg_wdata_i,
  output logic [sgpio_pkg::NUM_PINS-1:0] cfg_rdata_o,
  // pins
  input wire logic [sgpio_pkg::NUM_PINS-1:0] pin_i,
  output logic [sgpio_pkg::NUM_PINS-1:0] pin_o,
  output logic [sgpio_pkg::NUM_PINS-1:0] pin_oe_o,
  // alternate function sources from the core, active low
  input wire logic port2_reset_n_i,
  input wire logic port3_reset_n_i,
  input wire logic port4_reset_n_i,
  input wire logic port5_reset_n_i,
  input wire logic event_n_i,
  // expander interrupts toward the core, active low
  output logic expander_irq0_n_o,
  output logic expander_irq1_n_o,
  output logic expander_irq2_n_o
);
  import sgpio_pkg::*;

  logic [NUM_PINS-1:0] pin_function_select;
  logic [NUM_PINS-1:0] pin_direction_select;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_sample;
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic sample_tick;
  logic [NUM_PINS-1:0] alt_value;
  logic [NUM_PINS-1:0] next_pin_o;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic [NUM_PINS-1:0] next_level;
  logic [NUM_PINS-1:0] next_irq_n;
  logic [NUM_PINS-1:0] irq_n;
  logic [NUM_PINS-1:0] level_view;
  logic [NUM_PINS-1:0] rd_mux;
  logic sel_func;
  logic sel_dir;
  logic sel_level;
  logic wr_func;
  logic wr_dir;
  logic wr_level;

  ////////////////////////////////////////////////////////////////////////
  // register select decode

  // one select decode feeds both the write strobes and the read mux
  assign sel_func = (cfg_sel_i == REG_FUNC);
  assign sel_dir = (cfg_sel_i == REG_DIR);
  assign sel_level = (cfg_sel_i == REG_LEVEL);
  assign wr_func = cfg_wr_i && sel_func;
  assign wr_dir = cfg_wr_i && sel_dir;
  assign wr_level = cfg_wr_i && sel_level;

  ////////////////////////////////////////////////////////////////////////
  // input path

  // pins may move at any time, so two flops stand ahead of any use
  sgpio_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  // divider: one sample per 16 cycles keeps the rate at or below 128 ns
  // limitation: a pin change may wait a full divider period before it is seen
  assign sample_tick = (sample_cnt == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));

  // counter runs from reset, so the sample phase is fixed relative to reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sample_cnt <= '0;
    end else if (sample_tick) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + SAMPLE_CNT_W'(1);
    end
  end

  // held between ticks; anything between samples sees the last sample
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sample <= LEVEL_RESET;
    end else if (sample_tick) begin
      pin_sample <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  // mode bits are written whole; this port has no per-bit masking
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_function_select <= FUNC_RESET;
    end else if (wr_func) begin
      pin_function_select <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_direction_select <= DIR_RESET;
    end else if (wr_dir) begin
      pin_direction_select <= cfg_wdata_i;
    end
  end

  // alternate function value for each pin; unused positions stay high
  always_comb begin
    alt_value = '1;
    alt_value[PIN_P2_RST] = port2_reset_n_i;
    alt_value[PIN_P4_RST] = port4_reset_n_i;
    alt_value[PIN_P3_RST] = port3_reset_n_i;
    alt_value[PIN_P5_RST] = port5_reset_n_i;
    alt_value[PIN_EVENT] = event_n_i;
  end

  // per-pin mode decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      wire is_alt = pin_function_select[gi];
      wire is_out = !pin_function_select[gi] && pin_direction_select[gi];
      wire alt_drives = is_alt && ALT_OUT_MASK[gi];
      wire alt_listens = is_alt && ALT_IN_MASK[gi];
      // output pins keep the written value as their drive source
      assign next_level[gi] = is_out ? (wr_level ? cfg_wdata_i[gi] : pin_level[gi])
                                     : pin_sample[gi];
      // an output pin reads back the sampled pin, not its drive value, so a
      // pin pulled against its driver shows what is really on it
      assign level_view[gi] = is_out ? pin_sample[gi] : pin_level[gi];
      // pins 5, 6 and 8 have no alternate output and never drive in that mode
      assign next_pin_oe[gi] = is_out || alt_drives;
      assign next_pin_o[gi] = alt_drives ? alt_value[gi]
                                         : (is_out ? next_level[gi] : 1'b0);
      // interrupt seen only in alternate mode, else held inactive
      assign next_irq_n[gi] = alt_listens ? pin_sync[gi] : 1'b1;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registered pin and level state

  // one short block per register keeps each reset value beside its update
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_level <= LEVEL_RESET;
    end else begin
      pin_level <= next_level;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= '0;
    end else begin
      pin_o <= next_pin_o;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_oe_o <= '0;
    end else begin
      pin_oe_o <= next_pin_oe;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_n <= '1;
    end else begin
      irq_n <= next_irq_n;
    end
  end

  // disabled alternate outputs drive nothing, so alt sources being
  // active while in gpio mode never reach the pin
  assign expander_irq0_n_o = irq_n[PIN_IRQ0];
  assign expander_irq1_n_o = irq_n[PIN_IRQ1];
  assign expander_irq2_n_o = irq_n[PIN_IRQ2];

  ////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the read strobe

  // read data holds between reads so a slow reader sees a steady value;
  // an unmapped select matches none of the terms and reads as zero
  assign rd_mux = ({NUM_PINS{sel_func}} & pin_function_select) |
                  ({NUM_PINS{sel_dir}} & pin_direction_select) |
                  ({NUM_PINS{sel_level}} & level_view);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= '0;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= rd_mux;
    end
  end
endmodule

// ### verification/sgpio_chk.sv
`timescale 1ns/1ps
module sgpio_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [1:0] cfg_sel_i,
  input wire logic [10:0] cfg_wdata_i,
  input wire logic [10:0] cfg_rdata_o,
  input wire logic [10:0] pin_i,
  input wire logic [10:0] pin_oe_o,
  input wire logic [10:0] pin_o,
  input wire logic port2_reset_n_i,
  input wire logic expander_irq0_n_o
);
  import sgpio_pkg::*;
  logic [10:0] func_q, dir_q;
  // shadow of the mode registers, rebuilt from the write strobes
  wire [10:0] exp_oe = (func_q & ALT_OUT_MASK) | (~func_q & dir_q);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      func_q <= 11'h000;
      dir_q <= 11'h000;
    end else if (cfg_wr_i && cfg_sel_i == REG_FUNC) begin
      func_q <= cfg_wdata_i;
    end else if (cfg_wr_i && cfg_sel_i == REG_DIR) begin
      dir_q <= cfg_wdata_i;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  rst_idle_a: assert property ($fell(rst_i) |-> pin_oe_o == 11'h000)
    else $error("pins driven after reset");
  oe_map_a: assert property (pin_oe_o == $past(exp_oe))
    else $error("pin enables wrong");
  alt_rst_a: assert property (func_q[0] |=> pin_o[0] == $past(port2_reset_n_i))
    else $error("port reset not passed");
  irq_idle_a: assert property (!$past(func_q[2]) |-> expander_irq0_n_o)
    else $error("irq active in gp mode");
  irq_follow_a: assert property ($past(func_q[2]) && $past(func_q[2], 3)
    |-> expander_irq0_n_o == $past(pin_i[2], 3))
    else $error("irq not following pin");
  unmapped_read_a: assert property (cfg_rd_i && cfg_sel_i == 2'h3 |=> cfg_rdata_o == 11'h000)
    else $error("unmapped read not zero");
  func_rd_a: assert property (cfg_rd_i && cfg_sel_i == REG_FUNC |=> cfg_rdata_o == $past(func_q))
    else $error("function read wrong");
  rdata_hold_a: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data moved");
  cover property (cfg_wr_i && cfg_sel_i == REG_DIR);
  cover property (func_q[2] && !expander_irq0_n_o);
  cover property (func_q[5] && dir_q[5]);
endmodule
bind sgpio_pins sgpio_chk chk_u (.clock_i, .rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_sel_i,
  .cfg_wdata_i, .cfg_rdata_o, .pin_i, .pin_oe_o, .pin_o, .port2_reset_n_i, .expander_irq0_n_o);

// ### verification/sgpio_board.sv
`timescale 1ns/1ps
module sgpio_board (
  input wire logic clock_i,
  input wire logic [10:0] pin_o_i,
  input wire logic [10:0] pin_oe_i,
  input wire logic [10:0] ext_i,
  output logic [10:0] pin_lvl_o,
  output logic [10:0] seen_o
);
  logic [10:0] meta;
  // board parts drive only where the device lets go
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
  // device outputs are async to us, so two flops first
  always_ff @(posedge clock_i) begin
    meta <= pin_lvl_o;
    seen_o <= meta;
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sgpio_pkg::*;
  logic clock_i = 0, rst_i = 1, wr = 0, rd = 0, rd1 = 0, rd2 = 0, p2 = 1, p3 = 1, p4 = 1;
  logic p5 = 1, ev = 1;
  logic [1:0] sel = 0;
  logic [10:0] wd = 0, ext = 0, rdata, po, poe, lvl, seen, q[$];
  logic [31:0] lf = 32'h3828;
  logic [2:0] irq;
  int bad_count = 0, checked = 0;
  initial forever #4 clock_i = ~clock_i;
  sgpio_pins dut_u (.clock_i, .rst_i, .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_sel_i(sel),
    .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .pin_i(lvl), .pin_o(po), .pin_oe_o(poe),
    .port2_reset_n_i(p2), .port3_reset_n_i(p3), .port4_reset_n_i(p4), .port5_reset_n_i(p5),
    .event_n_i(ev), .expander_irq0_n_o(irq[0]), .expander_irq1_n_o(irq[1]),
    .expander_irq2_n_o(irq[2]));
  sgpio_board brd_u (.clock_i, .pin_o_i(po), .pin_oe_i(poe), .ext_i(ext), .pin_lvl_o(lvl),
    .seen_o(seen));
  ////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [10:0] sv, logic [10:0] ev_v);
    checked++;
    if (sv !== ev_v) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ev_v, sv);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one access; a read notes its expected data for the monitor
  task automatic acc(logic w, logic [1:0] s, logic [10:0] d);
    if (!w) q.push_back(d);
    wr <= w;
    rd <= !w;
    sel <= s;
    wd <= d;
    @(posedge clock_i);
    wr <= 0;
    rd <= 0;
    @(posedge clock_i);
  endtask
  always @(posedge clock_i) begin
    rd1 <= rd;
    rd2 <= rd1;
  end
  always @(negedge clock_i) begin
    if (rd2) check("read data", rdata, q.pop_front());
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    acc(0, REG_FUNC, FUNC_RESET);
    acc(0, REG_DIR, DIR_RESET);
    lf = lfsr_next(lf);
    acc(1, 2'h3, lf[10:0]);
    acc(0, 2'h3, 11'h000);
    ext <= lf[20:10];
    repeat (40) @(posedge clock_i);
    acc(0, REG_LEVEL, lf[20:10]);
    ext <= ~lf[20:10];
    acc(0, REG_LEVEL, lf[20:10]);
    lf = lfsr_next(lf);
    acc(1, REG_DIR, 11'h7FF);
    acc(1, REG_LEVEL, lf[10:0]);
    // the read shows the sampled pin, so let the divider catch the new drive
    repeat (24) @(posedge clock_i);
    acc(0, REG_LEVEL, lf[10:0]);
    check("pin level", seen, lf[10:0]);
    check("pin enable", poe, 11'h7FF);
    check("irq idle", {8'h00, irq}, 11'h007);
    {p2, p3, p4, p5, ev} <= lf[4:0];
    ext <= lf[15:5];
    acc(1, REG_FUNC, 11'h7FF);
    repeat (40) @(posedge clock_i);
    check("alt enable", poe, ALT_OUT_MASK);
    check("irq follow", {8'h00, irq}, {8'h00, lf[9:7]});
    acc(0, REG_LEVEL, (lf[15:5] & ~ALT_OUT_MASK) |
      {lf[1], lf[3], 1'b0, lf[0], 5'h00, lf[2], lf[4]});
    @(posedge clock_i);
    give_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule
